//--- psq_pkg.sv
// Constants, register map and types shared by the parameter set sequencer.
`default_nettype none
package psq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Sizes.
   localparam int PSQ_MAX_SETS = 16;
   localparam int PSQ_PARAM_W = 16;
   localparam int PSQ_ADDR_W = 8;
   localparam int PSQ_DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] PSQ_OFS_CTRL = 8'h00;
   localparam logic [7:0] PSQ_OFS_TOTAL = 8'h04;
   localparam logic [7:0] PSQ_OFS_BASE = 8'h08;
   localparam logic [7:0] PSQ_OFS_STATUS = 8'h0c;
   localparam logic [7:0] PSQ_OFS_ACTIVE = 8'h10;
   localparam logic [7:0] PSQ_OFS_SET_BASE = 8'h40;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int PSQ_CTRL_ENABLE = 0;
   localparam int PSQ_CTRL_ADV_SEL = 1;
   localparam int PSQ_CTRL_RST_EN = 2;
   localparam int PSQ_CTRL_INV1 = 3;
   localparam int PSQ_CTRL_INV2 = 4;
   localparam int PSQ_STAT_WAITING = 0;
   localparam int PSQ_STAT_RUNNING = 1;
   localparam int PSQ_STAT_IDX_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Values after reset.
   localparam logic [4:0] PSQ_TOTAL_RST = 5'h06;
   localparam logic [15:0] PSQ_BASE_RST = 16'h0000;
   localparam logic [15:0] PSQ_SET_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int PSQ_CLK_NS = 50;
   localparam int PSQ_LINE_BUSY_NS = 1000;
   localparam int PSQ_LINE_BUSY_CYC = (PSQ_LINE_BUSY_NS + PSQ_CLK_NS - 1) / PSQ_CLK_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [1:0] {
      PSQ_OFF = 2'h0,
      PSQ_LOAD = 2'h1,
      PSQ_WAIT = 2'h3,
      PSQ_BUSY = 2'h2
   } psq_state_t;

   typedef struct packed {
      logic inv2;
      logic inv1;
      logic rst_en;
      logic adv_sel;
      logic enable;
   } psq_ctrl_t;

   localparam psq_ctrl_t PSQ_CTRL_RST = '{default: 1'b0};

endpackage
`default_nettype wire

//--- psq_line_watch.sv
// Watches the two control lines and reports when they have been quiet long enough.
`timescale 1ns/1ps
`default_nettype none
module psq_line_watch import psq_pkg::*; #(
   parameter int BUSY_CYC = PSQ_LINE_BUSY_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Lines.
   input wire logic [1:0] line_in,
   // Status.
   output logic line_chg,
   output logic quiet
);

   localparam int CW = $clog2(BUSY_CYC + 1);
   localparam logic [CW-1:0] BUSY_LOAD = CW'(BUSY_CYC);

   logic [1:0] line_prev_ff;
   logic [CW-1:0] busy_cnt_ff;
   logic [CW-1:0] nxt_busy_cnt;

   initial begin
      if (BUSY_CYC < 2) begin
         $error("BUSY_CYC must be at least 2");
      end
   end

   // Any level change restarts the settle window.
   assign line_chg = (line_in != line_prev_ff);
   assign quiet = (busy_cnt_ff == '0) && !line_chg;
   assign nxt_busy_cnt = line_chg ? BUSY_LOAD :
                         (busy_cnt_ff != '0) ? busy_cnt_ff - 1'b1 : busy_cnt_ff;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         line_prev_ff <= 2'h0;
         busy_cnt_ff <= '0;
      end else begin
         line_prev_ff <= line_in;
         busy_cnt_ff <= nxt_busy_cnt;
      end
   end

endmodule
`default_nettype wire

//--- psq_top.sv
// Parameter set sequencer with line controlled advance and synchronous restart.
`timescale 1ns/1ps
`default_nettype none
module psq_top import psq_pkg::*; #(
   parameter int NUM_SETS = PSQ_MAX_SETS,
   parameter int PARAM_W = PSQ_PARAM_W,
   parameter int BUSY_CYC = PSQ_LINE_BUSY_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset,
   // Register port.
   input wire logic [PSQ_ADDR_W-1:0] addr,
   input wire logic [PSQ_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [PSQ_DATA_W-1:0] rdata,
   // Control lines and frame trigger.
   input wire logic line1,
   input wire logic line2,
   input wire logic frame_trig,
   // Sequencer outputs.
   output logic [PARAM_W-1:0] active_param,
   output logic [$clog2(NUM_SETS)-1:0] set_index,
   output logic waiting,
   output logic running,
   output logic frame_start
);

   localparam int IDX_W = $clog2(NUM_SETS);
   localparam int TOT_W = IDX_W + 1;
   localparam logic [TOT_W-1:0] TOT_MAX = TOT_W'(NUM_SETS);

   initial begin
      if (NUM_SETS < 2 || NUM_SETS > PSQ_MAX_SETS) begin
         $error("NUM_SETS must lie in 2..16");
      end
      if (PARAM_W < 1 || PARAM_W > PSQ_DATA_W) begin
         $error("PARAM_W must lie in 1..32");
      end
   end

   // Next index in the cycle, wrapping after the last configured set.
   function automatic logic [IDX_W-1:0] next_index(input logic [IDX_W-1:0] idx,
                                                   input logic [IDX_W-1:0] last);
      if (idx >= last) begin
         next_index = '0;
      end else begin
         next_index = idx + 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   psq_state_t state_ff;
   psq_state_t nxt_state;
   psq_ctrl_t ctrl_ff;
   logic [TOT_W-1:0] total_ff;
   logic [PARAM_W-1:0] base_ff;
   logic [PARAM_W-1:0] set_mem_ff [NUM_SETS];
   logic [PARAM_W-1:0] active_param_ff;
   logic [PARAM_W-1:0] nxt_active_param;
   logic [IDX_W-1:0] set_index_ff;
   logic [IDX_W-1:0] nxt_set_index;
   logic [PSQ_DATA_W-1:0] rdata_ff;
   logic trig_prev_ff;
   logic waiting_ff;
   logic running_ff;
   logic frame_start_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Line settle watcher.
   logic line_chg;
   logic quiet;

   psq_line_watch #(
      .BUSY_CYC(BUSY_CYC)
   ) u_watch (
      .clk_sys(clk_sys),
      .reset(reset),
      .line_in({line2, line1}),
      .line_chg(line_chg),
      .quiet(quiet)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode.
   wire [7:0] set_off = addr - PSQ_OFS_SET_BASE;
   wire set_hit = (addr >= PSQ_OFS_SET_BASE) && (set_off[1:0] == 2'h0) &&
                  (set_off[7:2] < 6'(NUM_SETS));
   wire [IDX_W-1:0] set_sel = set_off[IDX_W+1:2];
   wire wr_ctrl = wr && (addr == PSQ_OFS_CTRL);
   wire wr_total = wr && (addr == PSQ_OFS_TOTAL);
   wire wr_base = wr && (addr == PSQ_OFS_BASE);
   wire wr_set = wr && set_hit;

   wire [PSQ_DATA_W-1:0] ctrl_rd = PSQ_DATA_W'(ctrl_ff);
   wire [PSQ_DATA_W-1:0] stat_rd = (PSQ_DATA_W'(set_index_ff) << PSQ_STAT_IDX_LSB) |
                                   (PSQ_DATA_W'(running_ff) << PSQ_STAT_RUNNING) |
                                   (PSQ_DATA_W'(waiting_ff) << PSQ_STAT_WAITING);
   wire [PSQ_DATA_W-1:0] rd_mux =
      (addr == PSQ_OFS_CTRL) ? ctrl_rd :
      (addr == PSQ_OFS_TOTAL) ? PSQ_DATA_W'(total_ff) :
      (addr == PSQ_OFS_BASE) ? PSQ_DATA_W'(base_ff) :
      (addr == PSQ_OFS_STATUS) ? stat_rd :
      (addr == PSQ_OFS_ACTIVE) ? PSQ_DATA_W'(active_param_ff) :
      set_hit ? PSQ_DATA_W'(set_mem_ff[set_sel]) : '0;

   wire psq_ctrl_t ctrl_wr = '{
      inv2: wdata[PSQ_CTRL_INV2],
      inv1: wdata[PSQ_CTRL_INV1],
      rst_en: wdata[PSQ_CTRL_RST_EN],
      adv_sel: wdata[PSQ_CTRL_ADV_SEL],
      enable: wdata[PSQ_CTRL_ENABLE]
   };

   ////////////////////////////////////////////////////////////////////////////////
   // Set count, clamped so that the cycle never reaches an unstored set.
   wire [TOT_W-1:0] eff_total = (total_ff == '0) ? TOT_W'(1) :
                                (total_ff > TOT_MAX) ? TOT_MAX : total_ff;
   wire [TOT_W-1:0] last_tot = eff_total - 1'b1;
   wire [IDX_W-1:0] last_idx = last_tot[IDX_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Line decode and set selection.
   wire lvl1 = line1 ^ ctrl_ff.inv1;
   wire lvl2 = line2 ^ ctrl_ff.inv2;
   wire adv_act = ctrl_ff.adv_sel ? lvl2 : lvl1;
   wire rst_act = ctrl_ff.rst_en && (ctrl_ff.adv_sel ? lvl1 : lvl2);
   wire trig_rise = frame_trig && !trig_prev_ff;
   // A trigger counts only in the waiting state with the lines quiet in that very cycle.
   wire take = (state_ff == PSQ_WAIT) && quiet && trig_rise;
   wire [IDX_W-1:0] adv_idx = next_index(set_index_ff, last_idx);
   wire [IDX_W-1:0] sel_idx = rst_act ? '0 :
                              adv_act ? adv_idx : set_index_ff;
   wire do_load = rst_act || adv_act;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer state machine.
   always_comb begin
      nxt_state = state_ff;
      nxt_set_index = set_index_ff;
      nxt_active_param = active_param_ff;
      case (state_ff)
         PSQ_OFF: begin
            nxt_active_param = base_ff;
            if (ctrl_ff.enable) begin
               nxt_state = PSQ_LOAD;
               nxt_set_index = '0;
            end
         end
         PSQ_LOAD: begin
            nxt_active_param = set_mem_ff[set_index_ff];
            nxt_state = quiet ? PSQ_WAIT : PSQ_BUSY;
         end
         // A line change drops the waiting report until the lines have settled again.
         PSQ_WAIT: begin
            if (!quiet) begin
               nxt_state = PSQ_BUSY;
            end else if (take) begin
               nxt_set_index = sel_idx;
               if (do_load) begin
                  nxt_active_param = set_mem_ff[sel_idx];
               end
            end
         end
         PSQ_BUSY: begin
            if (quiet) begin
               nxt_state = PSQ_WAIT;
            end
         end
         default: begin
            nxt_state = PSQ_OFF;
         end
      endcase
      // Disabling wins over every state; a frame taken in that same cycle still steps set_index but raises no frame_start.
      if (!ctrl_ff.enable && state_ff != PSQ_OFF) begin
         nxt_state = PSQ_OFF;
         nxt_active_param = base_ff;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= PSQ_OFF;
         set_index_ff <= '0;
         active_param_ff <= PARAM_W'(PSQ_BASE_RST);
         waiting_ff <= 1'b0;
         running_ff <= 1'b0;
         frame_start_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         set_index_ff <= nxt_set_index;
         active_param_ff <= nxt_active_param;
         waiting_ff <= (nxt_state == PSQ_WAIT);
         running_ff <= (nxt_state != PSQ_OFF);
         frame_start_ff <= take && ctrl_ff.enable;
         trig_prev_ff <= frame_trig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_ff <= PSQ_CTRL_RST;
         total_ff <= TOT_W'(PSQ_TOTAL_RST);
         base_ff <= PARAM_W'(PSQ_BASE_RST);
         rdata_ff <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= ctrl_wr;
         end
         if (wr_total) begin
            total_ff <= wdata[TOT_W-1:0];
         end
         if (wr_base) begin
            base_ff <= wdata[PARAM_W-1:0];
         end
         // Read data stand for the one cycle after the strobe and read zero otherwise.
         rdata_ff <= rd ? rd_mux : '0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_SETS; i++) begin
            set_mem_ff[i] <= PARAM_W'(PSQ_SET_RST);
         end
      end else if (wr_set) begin
         set_mem_ff[set_sel] <= wdata[PARAM_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign rdata = rdata_ff;
   assign active_param = active_param_ff;
   assign set_index = set_index_ff;
   assign waiting = waiting_ff;
   assign running = running_ff;
   assign frame_start = frame_start_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Checks pause during reset, so the first edges after release see settled state.

   sequence s_enable_start;
      (state_ff == PSQ_OFF && ctrl_ff.enable) ##1 ctrl_ff.enable;
   endsequence

   sequence s_take_advance;
      take && ctrl_ff.enable && !rst_act && adv_act;
   endsequence

   AST_ENABLE_LOAD: assert property (s_enable_start |=>
      (active_param_ff == $past(set_mem_ff[0])) && (set_index_ff == '0))
      else $error("enable did not load set zero");

   AST_RESTART_ZERO: assert property (take && ctrl_ff.enable && rst_act |=>
      (set_index_ff == '0) && (active_param_ff == $past(set_mem_ff[0])))
      else $error("restart did not select set zero");

   AST_RESTART_PRIORITY: assert property (take && ctrl_ff.enable && rst_act && adv_act
      && set_index_ff != last_idx |=> set_index_ff == '0)
      else $error("advance overrode restart");

   AST_ADVANCE_NEXT: assert property (s_take_advance |=>
      set_index_ff == next_index($past(set_index_ff), $past(last_idx)))
      else $error("advance picked wrong set");

   AST_HOLD_SET: assert property (take && ctrl_ff.enable && !do_load |=>
      $stable(active_param_ff) && $stable(set_index_ff))
      else $error("idle lines changed the active set");

   AST_INDEX_RANGE: assert property (take && ctrl_ff.enable |=>
      set_index_ff <= $past(last_idx))
      else $error("set index beyond configured total");

   AST_RISING_ONLY: assert property (frame_start_ff |->
      $past(frame_trig) && !$past(frame_trig, 2))
      else $error("frame start without rising trigger");

   AST_IGNORE_BUSY: assert property (trig_rise && !(state_ff == PSQ_WAIT && quiet) |=>
      !frame_start_ff)
      else $error("trigger taken outside waiting state");

   AST_LINE_EXIT: assert property (line_chg && state_ff == PSQ_WAIT |=>
      !waiting_ff [*2])
      else $error("line change did not leave waiting state");

   AST_DISABLE_RESTORE: assert property (state_ff != PSQ_OFF && !ctrl_ff.enable |=>
      (state_ff == PSQ_OFF) && (active_param_ff == $past(base_ff)))
      else $error("disable did not restore base values");

   AST_SWAP_LINES: assert property (take && ctrl_ff.enable && ctrl_ff.rst_en &&
      ctrl_ff.adv_sel && (line1 ^ ctrl_ff.inv1) |=> set_index_ff == '0)
      else $error("swapped restart line not honoured");

   AST_SAMPLE_BOTH: assert property (take && ctrl_ff.enable && !rst_act && !adv_act ##1
      1'b1 |-> !$changed(set_index_ff))
      else $error("set changed with both lines inactive");

   AST_WRAP_ZERO: assert property (take && ctrl_ff.enable && !rst_act && adv_act &&
      set_index_ff == last_idx |=> set_index_ff == '0)
      else $error("advance past the last set did not wrap");

   AST_ADVANCE_LOAD: assert property (s_take_advance |=>
      active_param_ff == $past(set_mem_ff[adv_idx]))
      else $error("advance did not load the selected set");

   AST_OFF_BASE: assert property (state_ff == PSQ_OFF && !ctrl_ff.enable |=>
      active_param_ff == $past(base_ff))
      else $error("active values left base while off");

   AST_BUSY_NOT_WAITING: assert property (!quiet |=> !waiting_ff)
      else $error("waiting reported while lines were settling");

   AST_LEVEL_IGNORED: assert property (frame_trig && trig_prev_ff |=> !frame_start_ff)
      else $error("held trigger level started a frame");

endmodule
`default_nettype wire

//--- psq_trig_src.sv
// Behavioural model of the external source of the control lines and frame trigger.
`timescale 1ns/1ps
`default_nettype none
module psq_trig_src #(
   parameter int SETUP_CYC = 20,
   parameter int HOLD_CYC = 20
) (
   // Clock.
   input wire logic clk_sys,
   // Device status.
   input wire logic waiting,
   // Lines and trigger.
   output logic line1,
   output logic line2,
   output logic frame_trig
);
   initial begin
      line1 = 1'b0;
      line2 = 1'b0;
      frame_trig = 1'b0;
   end

   // Sets the lines, then raises the trigger for len cycles.
   // With obey low the trigger follows the line change at once, which must be ignored.
   task automatic frame(input logic l1, input logic l2, input logic obey, input int len);
      int n;
      n = 0;
      @(posedge clk_sys);
      line1 <= l1;
      line2 <= l2;
      if (obey) begin
         repeat (SETUP_CYC) @(posedge clk_sys);
         @(negedge clk_sys);
         while (waiting !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
         end
      end
      @(posedge clk_sys);
      frame_trig <= 1'b1;
      repeat (len) @(posedge clk_sys);
      frame_trig <= 1'b0;
      repeat (HOLD_CYC) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

//--- psq_top_test.sv
// Self-checking testbench for the parameter set sequencer.
`timescale 1ns/1ps
`default_nettype none
module psq_top_test import psq_pkg::*; ;
   localparam int N_SETS = 8;
   localparam int BUSY = 4;
   localparam int TIMEOUT_CYC = 5000;
   logic clk_sys, reset, wr, rd, line1, line2, frame_trig, waiting, running, frame_start;
   logic [PSQ_ADDR_W-1:0] addr;
   logic [PSQ_DATA_W-1:0] wdata, rdata;
   logic [15:0] active_param;
   logic [2:0] set_index;
   int errors = 0;
   int check_count = 0;
   int fs_cnt = 0;
   int low_cnt = 0;
   int cyc = 0;
   int exp_fs = 0;
   int snap = 0;

   ////////////////////////////////////////////////////////////////////////////////
   psq_top #(.NUM_SETS(N_SETS), .PARAM_W(16), .BUSY_CYC(BUSY)) uut (
      .clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .line1(line1), .line2(line2), .frame_trig(frame_trig),
      .active_param(active_param), .set_index(set_index), .waiting(waiting),
      .running(running), .frame_start(frame_start));
   psq_trig_src src (.clk_sys(clk_sys), .waiting(waiting), .line1(line1), .line2(line2),
      .frame_trig(frame_trig));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Counts accepted frames, cycles spent running but not waiting, and cuts a hang short.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (frame_start === 1'b1) begin
         fs_cnt <= fs_cnt + 1;
      end
      if (running === 1'b1 && waiting === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end
      if (cyc == TIMEOUT_CYC) begin
         errors++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [31:0] set_val(input int i);
      return 32'h00a0 + 32'(i);
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic reg_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      check(name, rdata, exp);
   endtask

   // One frame from the source, then the frame count, index and parameters are compared.
   task automatic step(input logic l1, input logic l2, input logic obey, input int len,
      input int idx);
      src.frame(l1, l2, obey, len);
      if (obey) begin
         exp_fs++;
      end
      check("frames", 32'(fs_cnt), 32'(exp_fs));
      check("set_index", {29'h0, set_index}, 32'(idx));
      check("active_param", {16'h0, active_param}, set_val(idx));
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      reg_chk("ctrl", PSQ_OFS_CTRL, 32'h0);
      reg_chk("total", PSQ_OFS_TOTAL, 32'h6);
      reg_chk("status", PSQ_OFS_STATUS, 32'h0);
      reg_chk("unmapped", 8'h20, 32'h0);
      wr_reg(PSQ_OFS_BASE, 32'h0bed);
      for (int i = 0; i < N_SETS; i++) begin
         wr_reg(PSQ_OFS_SET_BASE + 8'(4 * i), set_val(i));
      end
      wr_reg(PSQ_OFS_STATUS, 32'hff);
      reg_chk("status_ro", PSQ_OFS_STATUS, 32'h0);
      reg_chk("set5", PSQ_OFS_SET_BASE + 8'h14, set_val(5));
      reg_chk("active_off", PSQ_OFS_ACTIVE, 32'h0bed);
      // Line1 advances, line2 restarts, neither inverted.
      wr_reg(PSQ_OFS_CTRL, 32'h05);
      settle();
      check("running", {31'h0, running}, 32'h1);
      check("active_en", {16'h0, active_param}, set_val(0));
      step(1'b0, 1'b0, 1'b1, 1, 0);
      step(1'b1, 1'b0, 1'b1, 3, 1);
      step(1'b1, 1'b0, 1'b1, 1, 2);
      step(1'b0, 1'b1, 1'b1, 1, 0);
      step(1'b1, 1'b0, 1'b1, 1, 1);
      step(1'b1, 1'b1, 1'b1, 1, 0);
      step(1'b0, 1'b0, 1'b1, 1, 0);
      for (int i = 1; i <= 5; i++) begin
         step(1'b1, 1'b0, 1'b1, 1, i);
      end
      step(1'b1, 1'b0, 1'b1, 1, 0);
      reg_chk("status_run", PSQ_OFS_STATUS, 32'h3);
      step(1'b1, 1'b0, 1'b1, 1, 1);
      snap = low_cnt;
      step(1'b0, 1'b1, 1'b0, 1, 1);
      check("wait_drop", 32'(low_cnt - snap >= BUSY), 32'h1);
      step(1'b0, 1'b1, 1'b1, 1, 0);
      // Line2 advances, line1 restarts and is inverted.
      wr_reg(PSQ_OFS_CTRL, 32'h0f);
      step(1'b1, 1'b1, 1'b1, 1, 1);
      step(1'b0, 1'b1, 1'b1, 1, 0);
      // Line2 inverted advances, line1 restarts.
      wr_reg(PSQ_OFS_CTRL, 32'h17);
      step(1'b0, 1'b0, 1'b1, 1, 1);
      step(1'b1, 1'b0, 1'b1, 1, 0);
      // Restart switched off: a high restart line no longer matters.
      wr_reg(PSQ_OFS_CTRL, 32'h01);
      step(1'b1, 1'b1, 1'b1, 1, 1);
      wr_reg(PSQ_OFS_CTRL, 32'h00);
      settle();
      check("running_off", {31'h0, running}, 32'h0);
      check("waiting_off", {31'h0, waiting}, 32'h0);
      check("active_base", {16'h0, active_param}, 32'h0bed);
      src.frame(1'b0, 1'b0, 1'b0, 1);
      check("frames_off", 32'(fs_cnt), 32'(exp_fs));
      wr_reg(PSQ_OFS_CTRL, 32'h01);
      settle();
      check("index_reen", {29'h0, set_index}, 32'h0);
      check("active_reen", {16'h0, active_param}, set_val(0));
      // A shorter cycle of three sets wraps after set two.
      wr_reg(PSQ_OFS_TOTAL, 32'h3);
      reg_chk("total3", PSQ_OFS_TOTAL, 32'h3);
      step(1'b1, 1'b0, 1'b1, 1, 1);
      step(1'b1, 1'b0, 1'b1, 1, 2);
      step(1'b1, 1'b0, 1'b1, 1, 0);
      test_done();
   end
endmodule
`default_nettype wire
